// [rtl/ado_pkg.sv]
// Constants, types and encodings shared by the atomic and deferred-fault unit.
// Function
// - Semaphore reads, computes, writes back indivisibly.
// - Semaphores never speculative, no base update.
// - Swap returns old value, stores second source.
// - Compare-swap stores only when equal to compare value.
// - Fetch-add returns old value, stores sum.
// - Each general register carries a deferral flag.
// - Flagged register data is don't-care.
// - Floating token is one reserved pseudo-zero encoding.
// - Deferring writes token into the target.
// - Speculative loads defer instead of raising.
// - Speculative ops propagate source tokens to target.
// - Only speculative loads originate new tokens.
// - Check branches on token, else falls through.
// - Ops changing other state are non-speculative.
// - Compares on token clear or keep predicates.
// - Flag test writes two complementary predicates.
// - Class test keeps hit when token class tested.
// - Non-speculative token read raises consumption fault.
// - Non-speculative ops fault immediately.
// - Misaligned semaphore always faults.
// - Narrow loads zero-extend to full width.
package ado_pkg;
	// Operation codes presented on the issue port.
	typedef enum logic [3:0] {
		OP_LOAD, OP_STORE, OP_XCHG, OP_CMPXCHG, OP_FETCHADD,
		OP_ADD, OP_CMP, OP_TNAT, OP_FCLASS, OP_CHK
	} ado_op_type;
	// Sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} ado_state_type;
	// Fault codes.
	localparam logic [2:0] FLT_NONE = 3'h0;
	localparam logic [2:0] FLT_TOKEN = 3'h1;
	localparam logic [2:0] FLT_ALIGN = 3'h2;
	localparam logic [2:0] FLT_SPEC = 3'h3;
	localparam logic [2:0] FLT_MEM = 3'h4;
	// Access size codes, log2 of the byte count.
	localparam logic [1:0] SZ_1 = 2'h0;
	localparam logic [1:0] SZ_2 = 2'h1;
	localparam logic [1:0] SZ_4 = 2'h2;
	// Zero-extension masks per size.
	localparam logic [63:0] MASK_1 = 64'h00000000000000ff;
	localparam logic [63:0] MASK_2 = 64'h000000000000ffff;
	localparam logic [63:0] MASK_4 = 64'h00000000ffffffff;
	localparam logic [63:0] MASK_8 = 64'hffffffffffffffff;
	// Low address bits that must be zero per size.
	localparam logic [2:0] AL_1 = 3'h0;
	localparam logic [2:0] AL_2 = 3'h1;
	localparam logic [2:0] AL_4 = 3'h3;
	localparam logic [2:0] AL_8 = 3'h7;
	// Floating register format and its deferral encoding.
	localparam int FP_W = 82;
	localparam logic [81:0] FP_DEFER_ENC = {1'h0, 17'h1fffe, 64'h0};
	localparam logic [17:0] FP_HI_ZERO = 18'h0;
	// Class mask bits in the immediate of a class test.
	localparam int CLS_ZERO_BIT = 0;
	localparam int CLS_DEFER_BIT = 8;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_CCV_LO = 8'h00;
	localparam logic [7:0] OFF_CCV_HI = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_FCNT = 8'h10;
	// Control and status field positions.
	localparam int CTRL_ALIGN_BIT = 0;
	localparam int STAT_BUSY_BIT = 3;
	// Reset values.
	localparam logic [63:0] CCV_RST = 64'h0;
	localparam logic CTRL_ALIGN_RST = 1'h0;
endpackage

// [rtl/ado_core.sv]
// Atomic semaphore sequencer and deferred-exception token tracking.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ado_core
	import ado_pkg::*;
#(
	parameter int NGR = 128,
	parameter int IW = $clog2(NGR)
)(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RSTN,
	// Register bus.
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	// Issue port.
	input wire logic OP_VALID,
	input wire logic [3:0] OP_CODE,
	input wire logic OP_SPEC,
	input wire logic OP_UNC,
	input wire logic OP_FP,
	input wire logic [IW-1:0] OP_TGT,
	input wire logic [IW-1:0] OP_SRC1,
	input wire logic [IW-1:0] OP_SRC2,
	input wire logic [63:0] OP_IMM,
	input wire logic [1:0] OP_SIZE,
	input wire logic [63:0] OP_PC,
	input wire logic [FP_W-1:0] OP_FP_SRC,
	output logic OP_READY,
	// Pipeline register write port.
	input wire logic GW_VALID,
	input wire logic [IW-1:0] GW_IDX,
	input wire logic [63:0] GW_DATA,
	input wire logic GW_FLAG,
	// Results.
	output logic WB_VALID,
	output logic [IW-1:0] WB_TGT,
	output logic [63:0] WB_DATA,
	output logic WB_FLAG,
	output logic WB_FP_VALID,
	output logic [FP_W-1:0] WB_FP_DATA,
	output logic PRED_VALID,
	output logic PRED_P1,
	output logic PRED_P2,
	output logic BR_TAKEN,
	output logic [63:0] BR_TARGET,
	output logic FAULT_VALID,
	output logic [2:0] FAULT_CODE,
	// Memory port.
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [63:0] MEM_ADDR,
	output logic [1:0] MEM_SIZE,
	output logic [63:0] MEM_WDATA,
	output logic MEM_LOCK,
	input wire logic MEM_ACK,
	input wire logic [63:0] MEM_RDATA,
	input wire logic MEM_ERR
);
	// Zero-extends a loaded value to full width.
	function automatic logic [63:0] zext(input logic [63:0] d, input logic [1:0] s);
		case (s)
			SZ_1: zext = d & MASK_1;
			SZ_2: zext = d & MASK_2;
			SZ_4: zext = d & MASK_4;
			default: zext = d & MASK_8;
		endcase
	endfunction

	// Tells whether an address is off its natural boundary.
	function automatic logic misal(input logic [2:0] a, input logic [1:0] s);
		case (s)
			SZ_1: misal = |(a & AL_1);
			SZ_2: misal = |(a & AL_2);
			SZ_4: misal = |(a & AL_4);
			default: misal = |(a & AL_8);
		endcase
	endfunction

	// General register file: data plus one deferral flag each.
	logic [63:0] gr_data [NGR];
	logic [NGR-1:0] gr_flag_r;
	logic [NGR-1:0] gr_flag_nxt;
	// Software-visible registers.
	logic [63:0] ccv_r, ccv_nxt;
	logic align_chk_r, align_chk_nxt;
	logic [2:0] last_flt_r, last_flt_nxt;
	logic [31:0] fcnt_r, fcnt_nxt;
	// Bus data-phase bookkeeping.
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_nxt;
	// Sequencer state and latched operation.
	ado_state_type state_r, state_nxt;
	ado_op_type lat_op_r, lat_op_nxt;
	logic lat_spec_r, lat_spec_nxt;
	logic lat_fp_r, lat_fp_nxt;
	logic [IW-1:0] lat_tgt_r, lat_tgt_nxt;
	logic [63:0] lat_s2_r, lat_s2_nxt;
	logic [63:0] lat_imm_r, lat_imm_nxt;
	// Registered outputs and their next values.
	logic op_ready_nxt;
	logic wb_valid_nxt, wb_flag_nxt, wb_fp_valid_nxt;
	logic [IW-1:0] wb_tgt_nxt;
	logic [63:0] wb_data_nxt;
	logic [FP_W-1:0] wb_fp_data_nxt;
	logic pred_valid_nxt, pred_p1_nxt, pred_p2_nxt;
	logic br_taken_nxt;
	logic [63:0] br_target_nxt;
	logic fault_valid_nxt;
	logic [2:0] fault_code_nxt;
	logic mem_req_nxt, mem_we_nxt, mem_lock_nxt;
	logic [63:0] mem_addr_nxt, mem_wdata_nxt;
	logic [1:0] mem_size_nxt;
	// Decoded operand views.
	ado_op_type op;
	logic acc, f1, f2, fp_tok, is_sem, bad_al;
	logic [63:0] d1, d2, rdz;

	assign op = ado_op_type'(OP_CODE);
	assign acc = OP_VALID && OP_READY;
	assign f1 = gr_flag_r[OP_SRC1];
	assign f2 = gr_flag_r[OP_SRC2];
	assign d1 = gr_data[OP_SRC1];
	assign d2 = gr_data[OP_SRC2];
	assign fp_tok = (OP_FP_SRC == FP_DEFER_ENC);
	assign is_sem = (op == OP_XCHG) || (op == OP_CMPXCHG) || (op == OP_FETCHADD);
	assign bad_al = misal(d1[2:0], OP_SIZE);
	assign rdz = zext(MEM_RDATA, MEM_SIZE);

	// Sequencer next-state and result computation.
	always_comb
	begin
		state_nxt = state_r;
		lat_op_nxt = lat_op_r;
		lat_spec_nxt = lat_spec_r;
		lat_fp_nxt = lat_fp_r;
		lat_tgt_nxt = lat_tgt_r;
		lat_s2_nxt = lat_s2_r;
		lat_imm_nxt = lat_imm_r;
		// Result strobes last one cycle.
		wb_valid_nxt = 1'b0;
		wb_flag_nxt = 1'b0;
		wb_tgt_nxt = WB_TGT;
		wb_data_nxt = WB_DATA;
		wb_fp_valid_nxt = 1'b0;
		wb_fp_data_nxt = WB_FP_DATA;
		pred_valid_nxt = 1'b0;
		pred_p1_nxt = PRED_P1;
		pred_p2_nxt = PRED_P2;
		br_taken_nxt = 1'b0;
		br_target_nxt = BR_TARGET;
		fault_valid_nxt = 1'b0;
		fault_code_nxt = FAULT_CODE;
		mem_req_nxt = MEM_REQ;
		mem_we_nxt = MEM_WE;
		mem_lock_nxt = MEM_LOCK;
		mem_addr_nxt = MEM_ADDR;
		mem_size_nxt = MEM_SIZE;
		mem_wdata_nxt = MEM_WDATA;
		case (state_r)
			ST_IDLE:
			begin
				if (acc)
				begin
					lat_op_nxt = op;
					lat_spec_nxt = OP_SPEC;
					lat_fp_nxt = OP_FP;
					lat_tgt_nxt = OP_TGT;
					lat_s2_nxt = d2;
					lat_imm_nxt = OP_IMM;
					wb_tgt_nxt = OP_TGT;
					mem_addr_nxt = d1;
					mem_size_nxt = OP_SIZE;
					case (op)
						OP_XCHG, OP_CMPXCHG, OP_FETCHADD:
						begin
							// Faults are raised at once, never deferred.
							fault_valid_nxt = 1'b1;
							if (OP_SPEC)
								fault_code_nxt = FLT_SPEC;
							else if (f1 || (f2 && op != OP_FETCHADD))
								fault_code_nxt = FLT_TOKEN;
							else if (bad_al)
								fault_code_nxt = FLT_ALIGN;
							else
							begin
								// Locked read opens the indivisible pair.
								fault_valid_nxt = 1'b0;
								mem_req_nxt = 1'b1;
								mem_we_nxt = 1'b0;
								mem_lock_nxt = 1'b1;
								state_nxt = ST_RD;
							end
						end
						OP_LOAD:
						begin
							if (f1 || (bad_al && align_chk_r))
							begin
								if (OP_SPEC)
								begin
									// Speculative load originates a token.
									wb_valid_nxt = !OP_FP;
									wb_flag_nxt = 1'b1;
									wb_data_nxt = '0;
									wb_fp_valid_nxt = OP_FP;
									wb_fp_data_nxt = FP_DEFER_ENC;
								end
								else
								begin
									fault_valid_nxt = 1'b1;
									fault_code_nxt = f1 ? FLT_TOKEN : FLT_ALIGN;
								end
							end
							else
							begin
								mem_req_nxt = 1'b1;
								mem_we_nxt = 1'b0;
								state_nxt = ST_RD;
							end
						end
						OP_STORE:
						begin
							// Stores change memory, so the hint is ignored.
							if (f1 || f2)
							begin
								fault_valid_nxt = 1'b1;
								fault_code_nxt = FLT_TOKEN;
							end
							else if (bad_al && align_chk_r)
							begin
								fault_valid_nxt = 1'b1;
								fault_code_nxt = FLT_ALIGN;
							end
							else
							begin
								mem_req_nxt = 1'b1;
								mem_we_nxt = 1'b1;
								mem_wdata_nxt = d2;
								state_nxt = ST_WR;
							end
						end
						OP_ADD:
						begin
							if (!OP_SPEC && (f1 || f2))
							begin
								fault_valid_nxt = 1'b1;
								fault_code_nxt = FLT_TOKEN;
							end
							else
							begin
								// Token passes along, never created here.
								wb_valid_nxt = 1'b1;
								wb_flag_nxt = f1 || f2;
								wb_data_nxt = d1 + d2;
							end
						end
						OP_CMP:
						begin
							if (f1 || f2)
							begin
								// Unconditional type clears, others keep.
								pred_valid_nxt = OP_UNC;
								pred_p1_nxt = 1'b0;
								pred_p2_nxt = 1'b0;
							end
							else
							begin
								pred_valid_nxt = 1'b1;
								pred_p1_nxt = (d1 == d2);
								pred_p2_nxt = (d1 != d2);
							end
						end
						OP_TNAT:
						begin
							pred_valid_nxt = 1'b1;
							pred_p1_nxt = f1;
							pred_p2_nxt = !f1;
						end
						OP_FCLASS:
						begin
							if (fp_tok && OP_IMM[CLS_DEFER_BIT])
							begin
								// Token is itself a tested class: a hit.
								pred_valid_nxt = 1'b1;
								pred_p1_nxt = 1'b1;
								pred_p2_nxt = 1'b0;
							end
							else if (fp_tok)
							begin
								pred_valid_nxt = OP_UNC;
								pred_p1_nxt = 1'b0;
								pred_p2_nxt = 1'b0;
							end
							else
							begin
								pred_valid_nxt = 1'b1;
								pred_p1_nxt = OP_IMM[CLS_ZERO_BIT] && (OP_FP_SRC[80:0] == '0);
								pred_p2_nxt = !(OP_IMM[CLS_ZERO_BIT] && (OP_FP_SRC[80:0] == '0));
							end
						end
						OP_CHK:
						begin
							// Branch to recovery only when a token is seen.
							br_taken_nxt = OP_FP ? fp_tok : f1;
							br_target_nxt = OP_PC + OP_IMM;
						end
						default:
						begin
							fault_valid_nxt = 1'b0;
						end
					endcase
				end
			end
			ST_RD:
			begin
				if (MEM_ACK)
				begin
					mem_req_nxt = 1'b0;
					state_nxt = ST_IDLE;
					wb_tgt_nxt = lat_tgt_r;
					if (MEM_ERR)
					begin
						mem_lock_nxt = 1'b0;
						if (lat_spec_r && lat_op_r == OP_LOAD)
						begin
							wb_valid_nxt = !lat_fp_r;
							wb_flag_nxt = 1'b1;
							wb_data_nxt = '0;
							wb_fp_valid_nxt = lat_fp_r;
							wb_fp_data_nxt = FP_DEFER_ENC;
						end
						else
						begin
							fault_valid_nxt = 1'b1;
							fault_code_nxt = FLT_MEM;
						end
					end
					else
					begin
						wb_valid_nxt = !lat_fp_r || lat_op_r != OP_LOAD;
						wb_data_nxt = rdz;
						wb_fp_valid_nxt = lat_fp_r && lat_op_r == OP_LOAD;
						wb_fp_data_nxt = {FP_HI_ZERO, rdz};
						case (lat_op_r)
							OP_XCHG:
							begin
								mem_req_nxt = 1'b1;
								mem_we_nxt = 1'b1;
								mem_wdata_nxt = lat_s2_r;
								state_nxt = ST_WR;
							end
							OP_CMPXCHG:
							begin
								// Unequal value: no write, lock drops.
								mem_req_nxt = (rdz == ccv_r);
								mem_we_nxt = 1'b1;
								mem_wdata_nxt = lat_s2_r;
								mem_lock_nxt = (rdz == ccv_r);
								state_nxt = (rdz == ccv_r) ? ST_WR : ST_IDLE;
							end
							OP_FETCHADD:
							begin
								mem_req_nxt = 1'b1;
								mem_we_nxt = 1'b1;
								mem_wdata_nxt = zext(rdz + lat_imm_r, MEM_SIZE);
								state_nxt = ST_WR;
							end
							default:
							begin
								mem_lock_nxt = 1'b0;
							end
						endcase
					end
				end
			end
			ST_WR:
			begin
				// A semaphore's lock is held until the write is acknowledged; a plain store writes unlocked.
				if (MEM_ACK)
				begin
					mem_req_nxt = 1'b0;
					mem_lock_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
		op_ready_nxt = (state_nxt == ST_IDLE);
	end

	// Sequencer registers.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_r <= ST_IDLE;
			lat_op_r <= OP_LOAD;
			lat_spec_r <= 1'b0;
			lat_fp_r <= 1'b0;
			lat_tgt_r <= '0;
			lat_s2_r <= '0;
			lat_imm_r <= '0;
			OP_READY <= 1'b1;
			WB_VALID <= 1'b0;
			WB_TGT <= '0;
			WB_DATA <= '0;
			WB_FLAG <= 1'b0;
			WB_FP_VALID <= 1'b0;
			WB_FP_DATA <= '0;
			PRED_VALID <= 1'b0;
			PRED_P1 <= 1'b0;
			PRED_P2 <= 1'b0;
			BR_TAKEN <= 1'b0;
			BR_TARGET <= '0;
			FAULT_VALID <= 1'b0;
			FAULT_CODE <= FLT_NONE;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= '0;
			MEM_SIZE <= SZ_1;
			MEM_WDATA <= '0;
			MEM_LOCK <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			lat_op_r <= lat_op_nxt;
			lat_spec_r <= lat_spec_nxt;
			lat_fp_r <= lat_fp_nxt;
			lat_tgt_r <= lat_tgt_nxt;
			lat_s2_r <= lat_s2_nxt;
			lat_imm_r <= lat_imm_nxt;
			OP_READY <= op_ready_nxt;
			WB_VALID <= wb_valid_nxt;
			WB_TGT <= wb_tgt_nxt;
			WB_DATA <= wb_data_nxt;
			WB_FLAG <= wb_flag_nxt;
			WB_FP_VALID <= wb_fp_valid_nxt;
			WB_FP_DATA <= wb_fp_data_nxt;
			PRED_VALID <= pred_valid_nxt;
			PRED_P1 <= pred_p1_nxt;
			PRED_P2 <= pred_p2_nxt;
			BR_TAKEN <= br_taken_nxt;
			BR_TARGET <= br_target_nxt;
			FAULT_VALID <= fault_valid_nxt;
			FAULT_CODE <= fault_code_nxt;
			MEM_REQ <= mem_req_nxt;
			MEM_WE <= mem_we_nxt;
			MEM_ADDR <= mem_addr_nxt;
			MEM_SIZE <= mem_size_nxt;
			MEM_WDATA <= mem_wdata_nxt;
			MEM_LOCK <= mem_lock_nxt;
		end
	end

	// Register file flags: own results win over the pipeline port.
	always_comb
	begin
		gr_flag_nxt = gr_flag_r;
		if (GW_VALID)
			gr_flag_nxt[GW_IDX] = GW_FLAG;
		if (WB_VALID)
			gr_flag_nxt[WB_TGT] = WB_FLAG;
	end

	// Flag storage.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			gr_flag_r <= '0;
		else
			gr_flag_r <= gr_flag_nxt;
	end

	// Data storage has no reset; contents under a token are don't-care.
	always_ff @(posedge CLK)
	begin
		if (WB_VALID)
			gr_data[WB_TGT] <= WB_DATA;
		else if (GW_VALID)
			gr_data[GW_IDX] <= GW_DATA;
	end

	// Bus slave: zero wait states, writes land in the data phase.
	always_comb
	begin
		wr_pend_nxt = HSEL && HTRANS[1] && HREADY && HWRITE;
		wr_addr_nxt = HADDR[7:0];
		ccv_nxt = ccv_r;
		align_chk_nxt = align_chk_r;
		last_flt_nxt = FAULT_VALID ? FAULT_CODE : last_flt_r;
		fcnt_nxt = FAULT_VALID ? fcnt_r + 32'h1 : fcnt_r;
		hrdata_nxt = HRDATA;
		if (wr_pend_r)
		begin
			case (wr_addr_r)
				OFF_CCV_LO: ccv_nxt[31:0] = HWDATA;
				OFF_CCV_HI: ccv_nxt[63:32] = HWDATA;
				OFF_CTRL: align_chk_nxt = HWDATA[CTRL_ALIGN_BIT];
				default: ccv_nxt = ccv_r;
			endcase
		end
		if (HSEL && HTRANS[1] && HREADY && !HWRITE)
		begin
			// Unmapped addresses read as zero.
			case (HADDR[7:0])
				OFF_CCV_LO: hrdata_nxt = ccv_r[31:0];
				OFF_CCV_HI: hrdata_nxt = ccv_r[63:32];
				OFF_CTRL: hrdata_nxt = {31'h0, align_chk_r};
				OFF_STATUS: hrdata_nxt = {28'h0, !OP_READY, last_flt_r};
				OFF_FCNT: hrdata_nxt = fcnt_r;
				default: hrdata_nxt = '0;
			endcase
		end
	end

	// Bus slave registers.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			ccv_r <= CCV_RST;
			align_chk_r <= CTRL_ALIGN_RST;
			last_flt_r <= FLT_NONE;
			fcnt_r <= '0;
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			ccv_r <= ccv_nxt;
			align_chk_r <= align_chk_nxt;
			last_flt_r <= last_flt_nxt;
			fcnt_r <= fcnt_nxt;
			HRDATA <= hrdata_nxt;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Checks.
	sequence s_sem_go;
		acc && is_sem && !OP_SPEC && !f1 && !(f2 && op != OP_FETCHADD) && !bad_al;
	endsequence
	sequence s_cx_miss;
		state_r == ST_RD && MEM_ACK && !MEM_ERR && lat_op_r == OP_CMPXCHG && rdz != ccv_r;
	endsequence
	AST_SPEC_SEM: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && is_sem && OP_SPEC |=> FAULT_VALID && FAULT_CODE == FLT_SPEC && !MEM_REQ)
		else $error("speculative semaphore not refused");
	AST_SEM_LOCK: assert property (@(posedge CLK) disable iff (!RSTN)
		s_sem_go |=> MEM_LOCK && MEM_REQ && !MEM_WE)
		else $error("semaphore read issued without lock");
	AST_LOCK_WR: assert property (@(posedge CLK) disable iff (!RSTN)
		MEM_REQ && MEM_WE && lat_op_r != OP_STORE && state_r == ST_WR |-> MEM_LOCK)
		else $error("semaphore write without lock");
	AST_CX_MISS: assert property (@(posedge CLK) disable iff (!RSTN)
		s_cx_miss |=> !MEM_REQ && !MEM_LOCK && state_r == ST_IDLE)
		else $error("compare miss wrote memory");
	AST_ALIGN: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && is_sem && !OP_SPEC && !f1 && !(f2 && op != OP_FETCHADD) && bad_al
		|=> FAULT_VALID && FAULT_CODE == FLT_ALIGN)
		else $error("misaligned semaphore not faulted");
	AST_CONSUME: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && op == OP_ADD && !OP_SPEC && (f1 || f2) |=> FAULT_VALID && !WB_VALID)
		else $error("token consumed without fault");
	AST_PROP: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && op == OP_ADD && OP_SPEC |=> WB_VALID && WB_FLAG == $past(f1 || f2))
		else $error("token not propagated");
	AST_TNAT: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && op == OP_TNAT |=> PRED_VALID && PRED_P1 != PRED_P2 && PRED_P1 == $past(f1))
		else $error("flag test predicates wrong");
	AST_CHK: assert property (@(posedge CLK) disable iff (!RSTN)
		acc && op == OP_CHK && !OP_FP |=> BR_TAKEN == $past(f1))
		else $error("check branch wrong");
endmodule
`default_nettype wire

// [dv/ado_mem_model.sv]
// Memory partner that answers the core's plain and locked accesses.
`timescale 1ns/1ns
`default_nettype none
module ado_mem_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Request from the core.
	input wire logic req,
	input wire logic we,
	input wire logic [63:0] addr,
	input wire logic [1:0] size,
	input wire logic [63:0] wdata,
	// Answer delay and a forced read error.
	input wire logic [3:0] dly,
	input wire logic err_en,
	// Answer to the core.
	output logic ack,
	output logic [63:0] rdata,
	output logic err
);
	logic [63:0] mem_r [0:31]; // Words picked by address bits 7:3.
	logic [3:0] cnt_r; // Cycles the open request has waited.
	logic [63:0] msk; // Bytes that a write of this size changes.
	assign msk = (size == 2'h3) ? '1 : (64'h1 << (8 << size)) - 64'h1;
	// Answer after the delay; between answers the data lines keep toggling.
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack <= 1'h0;
			err <= 1'h0;
			rdata <= 64'h0;
			cnt_r <= 4'h0;
		end
		else if (req && !ack && cnt_r >= dly)
		begin
			ack <= 1'h1;
			err <= err_en && !we;
			rdata <= mem_r[addr[7:3]];
			cnt_r <= 4'h0;
			if (we)
				mem_r[addr[7:3]] <= (mem_r[addr[7:3]] & ~msk) | (wdata & msk);
		end
		else
		begin
			ack <= 1'h0;
			err <= ~err;
			rdata <= ~rdata;
			cnt_r <= (req && !ack) ? cnt_r + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// [dv/atomic_ops_and_deferred_faults_test.sv]
// Self-checking bench for the atomic and deferred-fault core.
`timescale 1ns/1ns
`default_nettype none
module atomic_ops_and_deferred_faults_test import ado_pkg::*;;
	// Design and partner signals.
	logic CLK, RSTN, HWRITE, HREADYOUT, HRESP, OP_VALID, OP_SPEC, OP_UNC, OP_FP, OP_READY;
	logic GW_VALID, GW_FLAG, WB_VALID, WB_FLAG, WB_FP_VALID, PRED_VALID, PRED_P1, PRED_P2;
	logic BR_TAKEN, FAULT_VALID, MEM_REQ, MEM_WE, MEM_LOCK, MEM_ACK, MEM_ERR, err_en;
	logic [1:0] HTRANS, OP_SIZE, MEM_SIZE;
	logic [2:0] HSIZE, FAULT_CODE, pr;
	logic [3:0] OP_CODE, dly, flt;
	logic [6:0] OP_TGT, OP_SRC1, OP_SRC2, GW_IDX, WB_TGT;
	logic [31:0] HADDR, HWDATA, HRDATA, rd;
	logic [63:0] OP_IMM, OP_PC, GW_DATA, WB_DATA, BR_TARGET, MEM_ADDR, MEM_WDATA, MEM_RDATA, mw;
	logic [64:0] wb, br;
	logic [FP_W-1:0] OP_FP_SRC, WB_FP_DATA, fpw;
	int miscompares, samples_checked, cyc;
	assign mw = i_ado_mem_model.mem_r[1];
	ado_core i_ado_core (.CLK, .RSTN, .HSEL(1'h1), .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
		.HREADY(HREADYOUT), .HREADYOUT, .HRDATA, .HRESP, .OP_VALID, .OP_CODE, .OP_SPEC, .OP_UNC,
		.OP_FP, .OP_TGT, .OP_SRC1, .OP_SRC2, .OP_IMM, .OP_SIZE, .OP_PC, .OP_FP_SRC, .OP_READY,
		.GW_VALID, .GW_IDX, .GW_DATA, .GW_FLAG, .WB_VALID, .WB_TGT, .WB_DATA, .WB_FLAG,
		.WB_FP_VALID, .WB_FP_DATA, .PRED_VALID, .PRED_P1, .PRED_P2, .BR_TAKEN, .BR_TARGET,
		.FAULT_VALID, .FAULT_CODE, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_SIZE, .MEM_WDATA,
		.MEM_LOCK, .MEM_ACK, .MEM_RDATA, .MEM_ERR);
	ado_mem_model i_ado_mem_model (.clk(CLK), .rstn(RSTN), .req(MEM_REQ), .we(MEM_WE),
		.addr(MEM_ADDR), .size(MEM_SIZE), .wdata(MEM_WDATA), .dly, .err_en, .ack(MEM_ACK),
		.rdata(MEM_RDATA), .err(MEM_ERR));
	// Core clock of 8 ns.
	initial
	begin
		CLK = 1'h0;
		forever #4 CLK = ~CLK;
	end
	// Latch result pulses and cut a hang short.
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (WB_VALID)
			wb <= {WB_FLAG, WB_DATA};
		if (WB_FP_VALID)
			fpw <= WB_FP_DATA;
		if (PRED_VALID)
			pr <= {1'h1, PRED_P1, PRED_P2};
		if (BR_TAKEN)
			br <= {1'h1, BR_TARGET};
		if (FAULT_VALID)
			flt <= {1'h1, FAULT_CODE};
		if (cyc == 3000)
		begin
			miscompares++;
			end_sim();
		end
	end
	// Compare a seen value with the expected one.
	task automatic chk(input string n, input logic [81:0] s, input logic [81:0] e);
		samples_checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// One single-word bus transfer; read data lands in rd.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		HSIZE <= 3'h2;
		do @(posedge CLK); while (HREADYOUT !== 1'h1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'h1);
		rd = HRDATA;
	endtask
	// Write a general register through the pipeline port.
	task automatic gw(input logic [6:0] i, input logic [63:0] d, input logic f);
		GW_VALID <= 1'h1;
		GW_IDX <= i;
		GW_DATA <= d;
		GW_FLAG <= f;
		@(posedge CLK);
		GW_VALID <= 1'h0;
		@(posedge CLK);
	endtask
	// Issue one operation, then wait until the core is idle again.
	task automatic op(input ado_op_type c, input logic s, input logic [6:0] t, a, b,
		input logic [63:0] i, input logic [1:0] z);
		OP_VALID <= 1'h1;
		OP_CODE <= c;
		OP_SPEC <= s;
		OP_TGT <= t;
		OP_SRC1 <= a;
		OP_SRC2 <= b;
		OP_IMM <= i;
		OP_SIZE <= z;
		do @(posedge CLK); while (OP_READY !== 1'h1);
		OP_VALID <= 1'h0;
		{wb, fpw, pr, br, flt} = '0;
		repeat (2) @(posedge CLK);
		while (OP_READY !== 1'h1)
			@(posedge CLK);
		@(posedge CLK);
	endtask
	// Print the counts and the verdict, then stop.
	task automatic end_sim();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Reset, preload, then run the tests in order.
	initial
	begin
		{RSTN, HTRANS, HADDR, HWRITE, HSIZE, HWDATA, OP_VALID, OP_CODE, OP_SPEC, OP_UNC} = '0;
		{OP_FP, OP_TGT, OP_SRC1, OP_SRC2, OP_IMM, OP_SIZE, OP_PC, OP_FP_SRC, dly} = '0;
		{GW_VALID, GW_IDX, GW_DATA, GW_FLAG, err_en, cyc, miscompares, samples_checked} = '0;
		for (int k = 0; k < 32; k++)
			i_ado_mem_model.mem_r[k] = 64'hffffffff80000001;
		repeat (3) @(posedge CLK);
		RSTN <= 1'h1;
		ahb(1'h1, 32'(OFF_CCV_LO), 32'h0000cafe);
		ahb(1'h0, 32'(OFF_CCV_LO), 32'h0);
		chk("ccv", rd, 32'h0000cafe);
		ahb(1'h0, 32'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("register test done");
		gw(7'h1, 64'h8, 1'h0);
		gw(7'h3, 64'hcafe, 1'h0);
		gw(7'h2, 64'h10, 1'h0);
		gw(7'h4, 64'h9, 1'h0);
		gw(7'h5, 64'h0, 1'h1);
		gw(7'h7, 64'h1234, 1'h0);
		dly <= 4'h3;
		op(OP_XCHG, 1'h0, 7'h6, 7'h1, 7'h3, 64'h0, SZ_4);
		chk("xchg", wb, {1'h0, 64'h80000001});
		chk("xchg_mem", mw, 64'hffffffff0000cafe);
		op(OP_CMPXCHG, 1'h0, 7'h6, 7'h1, 7'h7, 64'h0, SZ_4);
		chk("cas_hit", wb, 65'hcafe);
		op(OP_CMPXCHG, 1'h0, 7'h6, 7'h1, 7'h3, 64'h0, SZ_4);
		chk("cas_miss", wb, 65'h1234);
		chk("cas_mem", mw, 64'hffffffff00001234);
		op(OP_FETCHADD, 1'h0, 7'h6, 7'h1, 7'h0, 64'h5, SZ_4);
		chk("fadd", wb, 65'h1234);
		chk("fadd_mem", mw, 64'hffffffff00001239);
		op(OP_XCHG, 1'h1, 7'h6, 7'h1, 7'h3, 64'h0, SZ_4);
		chk("spec_sem", flt, {1'h1, FLT_SPEC});
		op(OP_FETCHADD, 1'h0, 7'h6, 7'h4, 7'h0, 64'h5, SZ_4);
		chk("misalign", flt, {1'h1, FLT_ALIGN});
		chk("sem_mem", mw, 64'hffffffff00001239);
		op(OP_STORE, 1'h0, 7'h0, 7'h1, 7'h7, 64'h0, SZ_4);
		chk("st_mem", mw, 64'hffffffff00001234);
		op(OP_STORE, 1'h1, 7'h0, 7'h1, 7'h5, 64'h0, SZ_4);
		chk("st_tok", flt, {1'h1, FLT_TOKEN});
		chk("st_tok_mem", mw, 64'hffffffff00001234);
		$display("semaphore test done");
		dly <= 4'h0;
		op(OP_LOAD, 1'h0, 7'h6, 7'h2, 7'h0, 64'h0, SZ_1);
		chk("ld_zext", wb, 65'h1);
		err_en <= 1'h1;
		op(OP_LOAD, 1'h1, 7'h6, 7'h2, 7'h0, 64'h0, SZ_4);
		chk("ld_spec", wb, {1'h1, 64'h0});
		op(OP_LOAD, 1'h0, 7'h6, 7'h2, 7'h0, 64'h0, SZ_4);
		chk("ld_err", flt, {1'h1, FLT_MEM});
		ahb(1'h1, 32'(OFF_CTRL), 32'h1);
		op(OP_LOAD, 1'h0, 7'h6, 7'h4, 7'h0, 64'h0, SZ_4);
		chk("ld_align", flt, {1'h1, FLT_ALIGN});
		OP_FP <= 1'h1;
		op(OP_LOAD, 1'h1, 7'h6, 7'h2, 7'h0, 64'h0, SZ_4);
		chk("fp_tok", fpw, FP_DEFER_ENC);
		OP_FP <= 1'h0;
		err_en <= 1'h0;
		$display("load test done");
		op(OP_ADD, 1'h1, 7'h8, 7'h5, 7'h3, 64'h0, SZ_1);
		chk("add_tok", wb[64], 1'h1);
		op(OP_ADD, 1'h1, 7'h8, 7'h7, 7'h3, 64'h0, SZ_1);
		chk("add_clean", wb, 65'hdd32);
		op(OP_ADD, 1'h0, 7'h8, 7'h5, 7'h3, 64'h0, SZ_1);
		chk("consume", flt, {1'h1, FLT_TOKEN});
		ahb(1'h0, 32'(OFF_STATUS), 32'h0);
		chk("status", rd, 32'h1);
		op(OP_TNAT, 1'h0, 7'h0, 7'h5, 7'h0, 64'h0, SZ_1);
		chk("tnat_tok", pr, 3'h6);
		op(OP_TNAT, 1'h0, 7'h0, 7'h3, 7'h0, 64'h0, SZ_1);
		chk("tnat_clean", pr, 3'h5);
		op(OP_CMP, 1'h0, 7'h0, 7'h5, 7'h3, 64'h0, SZ_1);
		chk("cmp_keep", pr, 3'h0);
		OP_UNC <= 1'h1;
		op(OP_CMP, 1'h0, 7'h0, 7'h5, 7'h3, 64'h0, SZ_1);
		chk("cmp_tok", pr, 3'h4);
		OP_PC <= 64'h1000;
		op(OP_CHK, 1'h0, 7'h0, 7'h5, 7'h0, 64'h40, SZ_1);
		chk("chk_br", br, {1'h1, 64'h1040});
		op(OP_CHK, 1'h0, 7'h0, 7'h3, 7'h0, 64'h40, SZ_1);
		chk("chk_seq", br, 65'h0);
		OP_FP_SRC <= FP_DEFER_ENC;
		op(OP_FCLASS, 1'h0, 7'h0, 7'h0, 7'h0, 64'h100, SZ_1);
		chk("fclass", pr, 3'h6);
		$display("token test done");
		end_sim();
	end
endmodule
`default_nettype wire
